// ---- hw/stepdir_params.svh ----
// constants of the step/direction output and homing block
`ifndef STEPDIR_PARAMS_SVH
`define STEPDIR_PARAMS_SVH
`define REG_IF_CONFIG     4'h0
`define REG_GLOBAL        4'h1
`define REG_TARGET_POS    4'h2
`define REG_ACTUAL_POS    4'h3
`define REG_TARGET_VEL    4'h4
`define REG_ACTUAL_VEL    4'h5
`define REG_MOTION_MODE   4'h6
`define REG_REF_TOLERANCE 4'h7
`define REG_LATCHED_POS   4'h8
`define REG_STATUS        4'h9
`define REG_REF_POSITION  4'ha
`define CFG_REF_INVERT    0
`define CFG_STEP_HALF     1
`define CFG_STEP_INVERT   2
`define CFG_DIR_INVERT    3
`define CFG_STEP_DIR_EN   4
`define GLB_RIGHT_EN      8
`define STS_MISMATCH      6
`define PULSE_UNIT        16
`define MIN_STEP_PERIOD   32
`define MODE_HOLD         2'h0
`define MODE_POSITION     2'h1
`define MODE_VELOCITY     2'h2
`endif

// ---- hw/stepdir_pkg.sv ----
// types and shared arithmetic of the step/direction block
package stepdir_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_GAP} step_state_t;
  typedef struct packed {
    logic step_dir_enable;
    logic dir_invert;
    logic step_invert;
    logic step_half;
    logic ref_invert;
  } if_config_t;
  typedef struct packed {
    logic left_active;
    logic right_active;
    logic in_window;
    logic left_rise;
  } switch_info_t;
  function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    abs_diff = d[31] ? (32'h0 - d) : d;
  endfunction
endpackage

// ---- hw/pulse_timer.sv ----
// programmable step pulse length timer
`timescale 1ns/1ps
module pulse_timer (
  input  wire logic       clk_in,   // system clock
  input  wire logic       rst_in,   // async reset, high
  input  wire logic       start_in, // load one pulse length
  input  wire logic [3:0] div_in,   // step pulse divider
  output logic            busy_out, // timer running
  output logic            done_out  // last cycle of the length
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       busy_q;
  logic       busy_d;
  // ************************************************************
  // length is 16*(div+1) cycles, loaded as div:f
  // ************************************************************
  always_comb
  begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    if (start_in)
    begin
      cnt_d  = {div_in, 4'hf};
      busy_d = 1'b1;
    end
    else if (busy_q)
    begin
      if (cnt_q == 8'h00)
        busy_d = 1'b0;
      else
        cnt_d = cnt_q - 8'h01;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end
  assign busy_out = busy_q;
  assign done_out = busy_q && (cnt_q == 8'h00);
endmodule

// ---- hw/switch_monitor.sv ----
// reference switch polarity, enables, tolerance window and edge
`timescale 1ns/1ps
module switch_monitor (
  input  wire logic        clk_in,    // system clock
  input  wire logic        rst_in,    // async reset, high
  input  wire logic        left_in,   // raw left switch level
  input  wire logic        right_in,  // raw right switch level
  input  wire logic        invert_in, // low level means active
  input  wire logic        right_en_in, // right switch in use
  input  wire logic [31:0] pos_in,    // actual position
  input  wire logic [31:0] ref_in,    // reference switch position
  input  wire logic [31:0] tol_in,    // tolerance around reference
  output stepdir_pkg::switch_info_t info_out // decoded switch state
);
  logic left_prev_q;
  logic left_prev_d;
  logic left_act;
  always_comb
  begin
    left_act    = left_in ^ invert_in;
    left_prev_d = left_act;
    info_out.left_active  = left_act;
    info_out.right_active = right_en_in && (right_in ^ invert_in);
    info_out.left_rise    = left_act && !left_prev_q;
    // zero tolerance disables the window entirely
    info_out.in_window = (tol_in != 32'h0) &&
      (stepdir_pkg::abs_diff(pos_in, ref_in) <= tol_in);
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      left_prev_q <= 1'b0;
    else
      left_prev_q <= left_prev_d;
  end
endmodule

// ---- hw/step_dir_output_and_homing.sv ----
// step/direction output stage with stop switches and position latch
// Contract
// - step pulse lasts 16 times (divider plus one) clock cycles
// - first pulse after direction change waits one pulse width
// - at most one step pulse per 32 clock cycles
// - step and direction driven only while step_dir_enable is set
// - active enabled stop switch halts motion automatically
// - nonzero tolerance suppresses the stop near reference position
// - any write to latched position re-arms the latch; a capture in the same cycle leaves it disarmed
// - armed latch captures position when reference switch activates moving
// - reference pass compares actual position against reference position
// - after setup, writing target position or velocity starts motion
// - hold mode, actual velocity, then position mode runs at start speed
// - half-rate mode toggles step output once per step
// - step and direction polarity invert independently, signs unchanged
// - polarity bit makes low active; right switch needs its enable
// - outputs high after power-on until the interface is configured
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "stepdir_params.svh"
module step_dir_output_and_homing (
  input  wire logic        SYS_CLK_IN,   // 200 MHz system clock
  input  wire logic        RST_IN,       // async reset, high
  input  wire logic [3:0]  ADDR_IN,      // register index
  input  wire logic [31:0] WDATA_IN,     // write data
  input  wire logic        WR_IN,        // write strobe
  input  wire logic        RD_IN,        // read strobe
  input  wire logic        REF_LEFT_IN,  // left stop/reference switch
  input  wire logic        REF_RIGHT_IN, // right stop switch
  output logic [31:0]      RDATA_OUT,    // read data, cycle after strobe
  output logic             STEP_OUT,     // step to driver stage
  output logic             DIR_OUT       // direction to driver stage
);
  // ************************************************************
  // register group
  // ************************************************************
  stepdir_pkg::if_config_t   cfg_q, cfg_d;
  stepdir_pkg::switch_info_t sw;
  stepdir_pkg::step_state_t  st_q, st_d;
  logic [3:0]  div_q, div_d;
  logic        right_en_q, right_en_d;
  logic [31:0] tpos_q, tpos_d, pos_q, pos_d, tvel_q, tvel_d, avel_q, avel_d;
  logic [31:0] tol_q, tol_d, latch_q, latch_d, refp_q, refp_d, rdata_q, rdata_d;
  logic [1:0]  mode_q, mode_d;
  logic        armed_q, armed_d, halt_q, halt_d, mism_q, mism_d;
  logic        conf_q, conf_d, dir_q, dir_d, lvl_q, lvl_d;
  logic [31:0] since_q, since_d, period;
  logic        want_move, want_dir, stop_hit, pulse_go, moving, t_start;
  logic        t_busy, t_done, wr_pos, wr_tpos;
  logic [31:0] status;

  assign wr_pos  = WR_IN && (ADDR_IN == `REG_ACTUAL_POS);
  assign wr_tpos = WR_IN && (ADDR_IN == `REG_TARGET_POS);
  assign moving  = (st_q != stepdir_pkg::ST_IDLE);
  assign status  = {25'h0, mism_q, halt_q, armed_q, sw.right_active,
                    sw.left_active, dir_q, moving};

  always_comb
  begin
    cfg_d = cfg_q;  div_d = div_q;  right_en_d = right_en_q;
    tpos_d = tpos_q;  tvel_d = tvel_q;  avel_d = avel_q;  mode_d = mode_q;
    tol_d = tol_q;  refp_d = refp_q;  latch_d = latch_q;  armed_d = armed_q;
    halt_d = halt_q;  mism_d = mism_q;  conf_d = conf_q;  rdata_d = 32'h0;
    if (WR_IN)
    begin
      if (ADDR_IN == `REG_IF_CONFIG)
      begin
        cfg_d = stepdir_pkg::if_config_t'(WDATA_IN[4:0]);
        conf_d = conf_q | WDATA_IN[`CFG_STEP_DIR_EN];
      end
      else if (ADDR_IN == `REG_GLOBAL)
      begin
        div_d = WDATA_IN[3:0];
        right_en_d = WDATA_IN[`GLB_RIGHT_EN];
      end
      else if (ADDR_IN == `REG_TARGET_POS)
      begin
        tpos_d = WDATA_IN;
        halt_d = 1'b0;
      end
      else if (ADDR_IN == `REG_TARGET_VEL)
      begin
        tvel_d = WDATA_IN;
        avel_d = WDATA_IN; // no ramp: velocity taken at once
        halt_d = 1'b0;
      end
      else if (ADDR_IN == `REG_ACTUAL_VEL)
        avel_d = WDATA_IN;
      else if (ADDR_IN == `REG_MOTION_MODE)
        mode_d = WDATA_IN[1:0];
      else if (ADDR_IN == `REG_REF_TOLERANCE)
        tol_d = WDATA_IN;
      else if (ADDR_IN == `REG_LATCHED_POS)
        armed_d = 1'b1;
      else if (ADDR_IN == `REG_REF_POSITION)
        refp_d = WDATA_IN;
      else if (ADDR_IN == `REG_STATUS && WDATA_IN[`STS_MISMATCH])
        mism_d = 1'b0;
    end
    // hardware events below override a same-cycle register write
    if (stop_hit)
      halt_d = 1'b1;
    if (armed_q && sw.left_rise && moving)
    begin
      latch_d = pos_q;
      armed_d = 1'b0;
    end
    if (sw.left_rise && stepdir_pkg::abs_diff(pos_q, refp_q) > tol_q)
      mism_d = 1'b1;
    if (RD_IN)
    begin
      if (ADDR_IN == `REG_IF_CONFIG)
        rdata_d = {27'h0, cfg_q};
      else if (ADDR_IN == `REG_GLOBAL)
        rdata_d = {23'h0, right_en_q, 4'h0, div_q};
      else if (ADDR_IN == `REG_TARGET_POS)
        rdata_d = tpos_q;
      else if (ADDR_IN == `REG_ACTUAL_POS)
        rdata_d = pos_q;
      else if (ADDR_IN == `REG_TARGET_VEL)
        rdata_d = tvel_q;
      else if (ADDR_IN == `REG_ACTUAL_VEL)
        rdata_d = avel_q;
      else if (ADDR_IN == `REG_MOTION_MODE)
        rdata_d = {30'h0, mode_q};
      else if (ADDR_IN == `REG_REF_TOLERANCE)
        rdata_d = tol_q;
      else if (ADDR_IN == `REG_LATCHED_POS)
        rdata_d = latch_q;
      else if (ADDR_IN == `REG_STATUS)
        rdata_d = status;
      else if (ADDR_IN == `REG_REF_POSITION)
        rdata_d = refp_q;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      cfg_q <= '0;  div_q <= 4'h0;  right_en_q <= 1'b0;
      tpos_q <= 32'h0;  tvel_q <= 32'h0;  avel_q <= 32'h0;  mode_q <= `MODE_HOLD;
      tol_q <= 32'h0;  refp_q <= 32'h0;  latch_q <= 32'h0;  armed_q <= 1'b0;
      halt_q <= 1'b0;  mism_q <= 1'b0;  conf_q <= 1'b0;  rdata_q <= 32'h0;
    end
    else
    begin
      cfg_q <= cfg_d;  div_q <= div_d;  right_en_q <= right_en_d;
      tpos_q <= tpos_d;  tvel_q <= tvel_d;  avel_q <= avel_d;  mode_q <= mode_d;
      tol_q <= tol_d;  refp_q <= refp_d;  latch_q <= latch_d;  armed_q <= armed_d;
      halt_q <= halt_d;  mism_q <= mism_d;  conf_q <= conf_d;  rdata_q <= rdata_d;
    end
  end
  assign RDATA_OUT = rdata_q;

  // ************************************************************
  // switches and step sequencer
  // ************************************************************
  switch_monitor u_sw (
    .clk_in      (SYS_CLK_IN),
    .rst_in      (RST_IN),
    .left_in     (REF_LEFT_IN),
    .right_in    (REF_RIGHT_IN),
    .invert_in   (cfg_q.ref_invert),
    .right_en_in (right_en_q),
    .pos_in      (pos_q),
    .ref_in      (refp_q),
    .tol_in      (tol_q),
    .info_out    (sw)
  );
  pulse_timer u_tmr (
    .clk_in   (SYS_CLK_IN),
    .rst_in   (RST_IN),
    .start_in (t_start),
    .div_in   (div_q),
    .busy_out (t_busy),
    .done_out (t_done)
  );

  always_comb
  begin
    // magnitude of actual velocity is the step period in cycles
    period = avel_q[31] ? (32'h0 - avel_q) : avel_q;
    if (mode_q == `MODE_VELOCITY)
    begin
      want_move = (avel_q != 32'h0);
      want_dir  = !avel_q[31];
    end
    else
    begin
      want_move = (mode_q == `MODE_POSITION) && (pos_q != tpos_q);
      want_dir  = $signed(tpos_q) > $signed(pos_q);
    end
    want_move = want_move && !halt_q && cfg_q.step_dir_enable;
    stop_hit = !sw.in_window && ((sw.left_active && !want_dir) ||
      (sw.right_active && want_dir)) && want_move;
    st_d = st_q;  dir_d = dir_q;  lvl_d = lvl_q;  pos_d = pos_q;
    since_d = (since_q == 32'hffffffff) ? since_q : since_q + 32'h1;
    t_start = 1'b0;
    pulse_go = 1'b0;
    case (st_q)
      stepdir_pkg::ST_IDLE:
        if (want_move && !stop_hit && !wr_pos)
        begin
          if (want_dir != dir_q)
          begin
            dir_d = want_dir;
            t_start = 1'b1;
            st_d = stepdir_pkg::ST_SETUP;
          end
          else if (since_q >= period)
          begin
            pulse_go = 1'b1;
            t_start = 1'b1;
            since_d = 32'h0;
            st_d = stepdir_pkg::ST_PULSE;
          end
        end
      stepdir_pkg::ST_SETUP:
        if (t_done)
          st_d = stepdir_pkg::ST_IDLE;
      stepdir_pkg::ST_PULSE:
        if (t_done)
        begin
          t_start = 1'b1; // gap equal to width keeps rate under clk/32
          st_d = stepdir_pkg::ST_GAP;
        end
      default:
        if (t_done)
          st_d = stepdir_pkg::ST_IDLE;
    endcase
    if (pulse_go)
    begin
      pos_d = dir_q ? pos_q + 32'h1 : pos_q - 32'h1;
      lvl_d = cfg_q.step_half ? !lvl_q : 1'b1;
    end
    else if (st_q == stepdir_pkg::ST_PULSE && t_done && !cfg_q.step_half)
      lvl_d = 1'b0;
    else if (wr_pos)
      pos_d = WDATA_IN;
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      st_q <= stepdir_pkg::ST_IDLE;
      dir_q <= 1'b1;
      lvl_q <= 1'b0;
      pos_q <= 32'h0;
      since_q <= 32'hffffffff;
    end
    else
    begin
      st_q <= st_d;
      dir_q <= dir_d;
      lvl_q <= lvl_d;
      pos_q <= pos_d;
      since_q <= since_d;
    end
  end

  // inversion touches only the pins, never internal signs
  always_comb
  begin
    if (!conf_q)
    begin
      STEP_OUT = 1'b1;
      DIR_OUT  = 1'b1;
    end
    else if (!cfg_q.step_dir_enable)
    begin
      STEP_OUT = cfg_q.step_invert;
      DIR_OUT  = cfg_q.dir_invert;
    end
    else
    begin
      STEP_OUT = lvl_q ^ cfg_q.step_invert;
      DIR_OUT  = dir_q ^ cfg_q.dir_invert;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [8:0] plen_q;
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      plen_q <= 9'h0;
    else
      // counts cycles of a pulse or of a direction setup; idle or gap clears it
      plen_q <= (st_q == stepdir_pkg::ST_PULSE || st_q == stepdir_pkg::ST_SETUP) ?
                plen_q + 9'h1 : 9'h0;
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_pulse_start;
    st_q != stepdir_pkg::ST_PULSE ##1 st_q == stepdir_pkg::ST_PULSE;
  endsequence
  sequence s_pulse_end;
    st_q == stepdir_pkg::ST_PULSE ##1 st_q == stepdir_pkg::ST_GAP;
  endsequence
  property p_width;
    s_pulse_end |-> $past(plen_q) == {1'b0, $past(div_q), 4'hf};
  endproperty
  a_width: assert property (p_width) else $error("pulse length wrong");
  sequence s_setup_end;
    st_q == stepdir_pkg::ST_SETUP ##1 st_q == stepdir_pkg::ST_IDLE;
  endsequence
  property p_dir_setup;
    $changed(dir_q) |-> st_q == stepdir_pkg::ST_SETUP && t_busy;
  endproperty
  a_dir_setup: assert property (p_dir_setup) else $error("no dir setup");
  property p_setup_len;
    s_setup_end |-> $past(plen_q) == {1'b0, $past(div_q), 4'hf};
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("dir setup length wrong");
  property p_rate;
    s_pulse_start |-> $past(since_q, 1) >= 32'd31;
  endproperty
  a_rate: assert property (p_rate) else $error("step rate too high");
  property p_disabled;
    conf_q && !cfg_q.step_dir_enable |-> STEP_OUT == cfg_q.step_invert;
  endproperty
  a_disabled: assert property (p_disabled) else $error("step while off");
  property p_stop;
    stop_hit |=> halt_q && st_q == stepdir_pkg::ST_IDLE || $past(moving);
  endproperty
  a_stop: assert property (p_stop) else $error("switch did not stop");
  property p_window;
    sw.in_window |-> !stop_hit;
  endproperty
  a_window: assert property (p_window) else $error("stop in window");
  property p_rearm;
    WR_IN && ADDR_IN == `REG_LATCHED_POS |=> armed_q;
  endproperty
  a_rearm: assert property (p_rearm) else $error("latch not armed");
  property p_capture;
    armed_q && sw.left_rise && moving |=> latch_q == $past(pos_q) && !armed_q;
  endproperty
  a_capture: assert property (p_capture) else $error("no capture");
  property p_half;
    cfg_q.step_half && $changed(lvl_q) |-> st_q == stepdir_pkg::ST_PULSE;
  endproperty
  a_half: assert property (p_half) else $error("half toggle late");
  property p_poweron;
    !conf_q |-> STEP_OUT && DIR_OUT;
  endproperty
  a_poweron: assert property (p_poweron) else $error("pins not high");
  property p_dir_stable;
    st_q == stepdir_pkg::ST_PULSE |-> $stable(dir_q);
  endproperty
  a_dir_stable: assert property (p_dir_stable) else $error("dir in pulse");
  property p_count;
    s_pulse_start |-> pos_q == (dir_q ? $past(pos_q) + 32'h1 : $past(pos_q) - 32'h1);
  endproperty
  a_count: assert property (p_count) else $error("position step wrong");
endmodule

// ---- verification/driver_stage_model.sv ----
// stepper driver stage model that counts and times the step/direction pins
`timescale 1ns/1ps
module driver_stage_model (
  input  wire logic          clk_in,      // system clock
  input  wire logic          clear_in,    // restart spacing, setup and dir-error statistics
  input  wire logic          step_in,     // step pin
  input  wire logic          dir_in,      // direction pin
  input  wire logic          step_inv_in, // step polarity inverted
  input  wire logic          dir_inv_in,  // direction polarity inverted
  input  wire logic          half_in,     // both edges are steps
  output logic signed [31:0] count_out,   // net steps seen
  output int                 width_out,   // last high time
  output int                 period_out,  // shortest step spacing
  output int                 setup_out,   // shortest dir-to-step time
  output int                 dir_err_out  // dir moved inside a pulse
);
  logic lvl_q   = 1'b0;
  logic dir_q   = 1'b1;
  logic moved_q = 1'b0;
  logic seen_q  = 1'b0;
  int   hi_cnt  = 0;
  int   since   = 0;
  int   since_d = 0;
  initial
  begin
    count_out   = 0;
    width_out   = 0;
    period_out  = 99999;
    setup_out   = 99999;
    dir_err_out = 0;
  end
  always @(posedge clk_in)
  begin
    logic lvl;
    logic fire;
    lvl  = step_in ^ step_inv_in;
    fire = half_in ? (lvl != lvl_q) : (lvl && !lvl_q);
    if (dir_in != dir_q && lvl && lvl_q && !half_in)
      dir_err_out <= dir_err_out + 1;
    hi_cnt <= lvl ? hi_cnt + 1 : 0;
    if (lvl_q && !lvl)
      width_out <= hi_cnt;
    since   <= fire ? 1 : since + 1;
    since_d <= (dir_in != dir_q) ? 1 : since_d + 1;
    if (dir_in != dir_q)
      moved_q <= 1'b1;
    if (fire)
    begin
      count_out <= count_out + ((dir_in ^ dir_inv_in) ? 1 : -1);
      seen_q    <= 1'b1;
      moved_q   <= 1'b0;
      if (seen_q && since < period_out)
        period_out <= since;
      if (moved_q && since_d < setup_out)
        setup_out <= since_d;
    end
    if (clear_in)
    begin
      seen_q      <= 1'b0;
      moved_q     <= 1'b0;
      period_out  <= 99999;
      setup_out   <= 99999;
      dir_err_out <= 0;
    end
    lvl_q <= lvl;
    dir_q <= dir_in;
  end
endmodule

// ---- verification/step_dir_output_and_homing_bench.sv ----
// self-checking bench of the step/direction output and homing block
`timescale 1ns/1ps
`include "stepdir_params.svh"
module step_dir_output_and_homing_bench;
  logic              SYS_CLK_IN = 1'b0;
  logic              RST_IN = 1'b1;
  logic [3:0]        ADDR_IN = 4'h0;
  logic [31:0]       WDATA_IN = 32'h0;
  logic              WR_IN = 1'b0;
  logic              RD_IN = 1'b0;
  logic              REF_LEFT_IN = 1'b0;
  logic              REF_RIGHT_IN = 1'b0;
  logic [31:0]       RDATA_OUT;
  logic              STEP_OUT;
  logic              DIR_OUT;
  logic [4:0]        cfg = 5'h00;
  logic              clear = 1'b0;
  logic signed [31:0] mcount;
  int                mwidth, mperiod, msetup, mdirerr;
  int                fails = 0;
  int                comparisons = 0;
  logic [31:0]       pos, val, lat;
  logic signed [31:0] c0;
  always #2.5 SYS_CLK_IN = ~SYS_CLK_IN;
  step_dir_output_and_homing u_dut (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .REF_LEFT_IN(REF_LEFT_IN), .REF_RIGHT_IN(REF_RIGHT_IN), .RDATA_OUT(RDATA_OUT),
    .STEP_OUT(STEP_OUT), .DIR_OUT(DIR_OUT));
  driver_stage_model u_drv (.clk_in(SYS_CLK_IN), .clear_in(clear), .step_in(STEP_OUT),
    .dir_in(DIR_OUT), .step_inv_in(cfg[2]), .dir_inv_in(cfg[3]), .half_in(cfg[1]),
    .count_out(mcount), .width_out(mwidth), .period_out(mperiod), .setup_out(msetup),
    .dir_err_out(mdirerr));
  // ************************************************************
  // expectations and bus tasks
  // ************************************************************
  function automatic int pulse_len(input logic [3:0] div);
    return `PULSE_UNIT * (div + 1);
  endfunction
  function automatic int min_gap(input logic [3:0] div, input int vel);
    return (vel > `MIN_STEP_PERIOD * (div + 1)) ? vel : `MIN_STEP_PERIOD * (div + 1);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge SYS_CLK_IN);
    ADDR_IN  <= a;
    WDATA_IN <= d;
    WR_IN    <= 1'b1;
    @(posedge SYS_CLK_IN);
    WR_IN    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge SYS_CLK_IN);
    ADDR_IN <= a;
    RD_IN   <= 1'b1;
    @(posedge SYS_CLK_IN);
    RD_IN   <= 1'b0;
    #1 d = RDATA_OUT;
  endtask
  task automatic set_cfg(input logic [4:0] v);
    cfg <= v;
    wr(`REG_IF_CONFIG, {27'h0, v});
  endtask
  task automatic wait_pos(input logic [31:0] exp);
    for (int i = 0; i < 200; i++)
    begin
      rd(`REG_ACTUAL_POS, val);
      if (val === exp)
        break;
      repeat (20) @(posedge SYS_CLK_IN);
    end
  endtask
  // start-stop sequence: hold, target, start speed, then position mode
  task automatic move(input logic [3:0] div, input int n, input int vel, input bit chk_w);
    wr(`REG_GLOBAL, {28'h0, div});
    wr(`REG_MOTION_MODE, {30'h0, `MODE_HOLD});
    rd(`REG_ACTUAL_POS, pos);
    clear <= 1'b1;
    @(posedge SYS_CLK_IN);
    clear <= 1'b0;
    c0 = mcount;
    wr(`REG_TARGET_POS, pos + n);
    wr(`REG_ACTUAL_VEL, (n < 0) ? -vel : vel);
    wr(`REG_MOTION_MODE, {30'h0, `MODE_POSITION});
    wait_pos(pos + n);
    repeat (pulse_len(div) + 4) @(posedge SYS_CLK_IN);
    check(val, pos + n);
    check(mcount - c0, n);
    if (chk_w)
      check(mwidth, pulse_len(div));
    check(mperiod >= min_gap(div, vel), 1);
    check(msetup >= pulse_len(div), 1);
    check(mdirerr, 0);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    int n;
    void'($urandom(98420));
    repeat (2) @(posedge SYS_CLK_IN);
    RST_IN <= 1'b0;
    @(negedge SYS_CLK_IN);
    check({STEP_OUT, DIR_OUT}, 2'b11);
    rd(`REG_STATUS, val);
    check(val, 32'h2);
    rd(4'hf, val);
    check(val, 32'h0);
    wr(`REG_ACTUAL_POS, 32'd100);
    set_cfg(5'h10);
    @(negedge SYS_CLK_IN);
    check(STEP_OUT, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      n = $urandom_range(6, 2);
      move($urandom_range(3, 0), (i % 2) ? -n : n, (i == 4) ? 80 : 0, 1'b1);
    end
    set_cfg(5'h1c);
    move(4'h0, 3, 0, 1'b1);
    move(4'h1, -2, 0, 1'b1);
    set_cfg(5'h12);
    move(4'h0, 4, 0, 1'b0);
    move(4'h0, -4, 0, 1'b0);
    // disabled interface must neither pulse nor count
    set_cfg(5'h0c);
    rd(`REG_ACTUAL_POS, pos);
    wr(`REG_TARGET_POS, pos + 5);
    repeat (300) @(posedge SYS_CLK_IN);
    check({STEP_OUT, DIR_OUT}, 2'b11);
    rd(`REG_ACTUAL_POS, val);
    check(val, pos);
    wr(`REG_TARGET_POS, pos);
    set_cfg(5'h10);
    // homing: arm latch, run toward 1000 steps below, hit the switch in a gap
    wr(`REG_GLOBAL, 32'h1);
    wr(`REG_LATCHED_POS, 32'h5a5a);
    c0 = mcount;
    wr(`REG_TARGET_POS, pos - 1000);
    for (int i = 0; i < 2000 && mcount != c0 - 3; i++)
      @(posedge SYS_CLK_IN);
    repeat (40) @(posedge SYS_CLK_IN);
    REF_LEFT_IN <= 1'b1;
    repeat (300) @(posedge SYS_CLK_IN);
    lat = pos - 3;
    rd(`REG_LATCHED_POS, val);
    check(val, lat);
    rd(`REG_ACTUAL_POS, val);
    check(val, lat);
    rd(`REG_STATUS, val);
    check(val[6:5], 2'b11);
    wr(`REG_REF_POSITION, lat);
    wr(`REG_REF_TOLERANCE, 32'd5);
    wr(`REG_TARGET_POS, lat - 1000);
    wait_pos(lat - 6);
    repeat (300) @(posedge SYS_CLK_IN);
    rd(`REG_ACTUAL_POS, val);
    check(val, lat - 6);
    REF_LEFT_IN <= 1'b0;
    wr(`REG_MOTION_MODE, {30'h0, `MODE_HOLD});
    wr(`REG_ACTUAL_POS, 32'h0);
    wr(`REG_TARGET_POS, 32'h0);
    wr(`REG_MOTION_MODE, {30'h0, `MODE_POSITION});
    repeat (200) @(posedge SYS_CLK_IN);
    rd(`REG_ACTUAL_POS, val);
    check(val, 32'h0);
    // inverted switches: high left is idle, right counts only once enabled
    set_cfg(5'h11);
    REF_LEFT_IN  <= 1'b1;
    REF_RIGHT_IN <= 1'b0;
    move(4'h0, 3, 0, 1'b1);
    wr(`REG_GLOBAL, 32'h100);
    wr(`REG_TARGET_POS, 32'd10);
    repeat (300) @(posedge SYS_CLK_IN);
    rd(`REG_ACTUAL_POS, val);
    check(val, 32'd3);
    rd(`REG_STATUS, val);
    check(val[5], 1'b1);
    test_done;
  end
  initial
  begin
    #400000;
    fails++;
    test_done;
  end
endmodule
